// [core/route_lookup.v]
// hashed layer-3 and mpls route lookup with table write port
// Operation
// - four buckets per fourteen-bit hash row
// - row from vrf+ip or port+label hash
// - compare address in all row buckets
// - protocol must also match, vrf too for ip
// - matching bucket drives next-hop result
// - add multipath offset to next-hop index
// - bit0 family, bit1 ip versus mpls
// - ipv4 compares only low 32 bits
// - mpls: port low four, label above
// - select bit zero means use hash
// - mask multipath hash with entry mask
// - shift masked hash right by field
`timescale 1ns/1ps
`default_nettype none
`include "route_defs.vh"
module route_lookup #(
  parameter ROW_BITS = `RT_ROW_BITS,
  parameter HASH_W = 6
) (
  // clock and reset
  input wire CLK,
  input wire RSTN,
  // table access: index = {bucket, row}
  input wire CFG_WR,
  input wire CFG_RD,
  input wire [ROW_BITS+1:0] CFG_INDEX,
  input wire [`RT_ENTRY_W-1:0] CFG_WDATA,
  output reg [`RT_ENTRY_W-1:0] CFG_RDATA,
  output reg CFG_RVALID,
  // lookup request
  input wire LK_VALID,
  input wire LK_MPLS,
  input wire LK_FAMILY,
  input wire [1:0] LK_VRF,
  input wire [127:0] LK_ADDR,
  input wire [3:0] LK_SRC_PORT,
  input wire [19:0] LK_LABEL,
  input wire [HASH_W-1:0] LK_MP_HASH,
  // lookup result
  output reg RES_VALID,
  output reg RES_HIT,
  output reg RES_MISS,
  output reg [10:0] RES_NEXT_HOP,
  output reg [2:0] RES_GENERATION
);
  localparam ROWS = 1 << ROW_BITS;
  // two-flop release; entry into reset stays asynchronous
  reg rstn_s1_q;
  reg rstn_q;
  wire rstn_i = rstn_q;
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rstn_s1_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rstn_s1_q <= 1'b1;
      rstn_q <= rstn_s1_q;
    end
  end

  // one array per bucket so a row reads all four at once
  // entries are not reset: software writes a row before use
  reg [`RT_ENTRY_W-1:0] bank0 [0:ROWS-1];
  reg [`RT_ENTRY_W-1:0] bank1 [0:ROWS-1];
  reg [`RT_ENTRY_W-1:0] bank2 [0:ROWS-1];
  reg [`RT_ENTRY_W-1:0] bank3 [0:ROWS-1];
  wire [ROW_BITS-1:0] cfg_row = CFG_INDEX[ROW_BITS-1:0];
  wire [1:0] cfg_bkt = CFG_INDEX[ROW_BITS+1:ROW_BITS];

  always @(posedge CLK) begin
    if (CFG_WR) begin
      case (cfg_bkt)
        2'd0: bank0[cfg_row] <= CFG_WDATA;
        2'd1: bank1[cfg_row] <= CFG_WDATA;
        2'd2: bank2[cfg_row] <= CFG_WDATA;
        default: bank3[cfg_row] <= CFG_WDATA;
      endcase
    end
  end

  // read port shares the index with the write port
  reg [`RT_ENTRY_W-1:0] rd_sel;
  always @* begin
    case (cfg_bkt)
      2'd0: rd_sel = bank0[cfg_row];
      2'd1: rd_sel = bank1[cfg_row];
      2'd2: rd_sel = bank2[cfg_row];
      default: rd_sel = bank3[cfg_row];
    endcase
  end

  always @(posedge CLK or negedge rstn_i) begin
    if (!rstn_i) begin
      CFG_RDATA <= `RT_ENTRY_RESET;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD;
      if (CFG_RD)
        CFG_RDATA <= rd_sel;
    end
  end

  // key build and row hash
  // ip row hash xors the vrf into the key's two low bits
  reg [127:0] key_addr;
  reg [ROW_BITS-1:0] row_hash;
  integer i;
  always @* begin
    key_addr = 128'h0;
    row_hash = {ROW_BITS{1'b0}};
    if (LK_MPLS) begin
      key_addr[23:0] = {LK_LABEL, LK_SRC_PORT};
      row_hash = fold({104'h0, LK_LABEL, LK_SRC_PORT});
    end else begin
      key_addr = LK_FAMILY ? LK_ADDR : {96'h0, LK_ADDR[31:0]};
      row_hash = fold(key_addr ^ {126'h0, LK_VRF});
    end
  end

  // xor fold of a 128-bit key to the row width
  function [ROW_BITS-1:0] fold;
    input [127:0] k;
    integer j;
    begin
      fold = {ROW_BITS{1'b0}};
      for (j = 0; j < 128; j = j + 1)
        fold[j % ROW_BITS] = fold[j % ROW_BITS] ^ k[j];
    end
  endfunction

  // row read, registered with the key
  reg [`RT_ENTRY_W-1:0] e0_q;
  reg [`RT_ENTRY_W-1:0] e1_q;
  reg [`RT_ENTRY_W-1:0] e2_q;
  reg [`RT_ENTRY_W-1:0] e3_q;
  reg v_q, mpls_q, fam_q;
  reg [1:0] vrf_q;
  reg [127:0] key_q;
  reg [HASH_W-1:0] hash_q;
  always @(posedge CLK) begin
    e0_q <= bank0[row_hash];
    e1_q <= bank1[row_hash];
    e2_q <= bank2[row_hash];
    e3_q <= bank3[row_hash];
    mpls_q <= LK_MPLS;
    fam_q <= LK_FAMILY;
    vrf_q <= LK_VRF;
    key_q <= key_addr;
    hash_q <= LK_MP_HASH;
  end
  // only the valid flag needs a reset
  always @(posedge CLK or negedge rstn_i) begin
    if (!rstn_i)
      v_q <= 1'b0;
    else
      v_q <= LK_VALID;
  end

  wire [3:0] hits;
  wire [`RT_ENTRY_W*4-1:0] row = {e3_q, e2_q, e1_q, e0_q};
  // one comparator per bucket of the row
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : cmp
      route_bucket_cmp u_cmp (
        .entry(row[g*`RT_ENTRY_W +: `RT_ENTRY_W]),
        .key_family(fam_q),
        .key_mpls(mpls_q),
        .key_vrf(vrf_q),
        .key_addr(key_q),
        .hit(hits[g])
      );
    end
  endgenerate

  // lowest matching bucket wins
  reg [`RT_ENTRY_W-1:0] win;
  always @* begin
    win = e0_q;
    for (i = 3; i >= 0; i = i - 1)
      if (hits[i])
        win = row[i*`RT_ENTRY_W +: `RT_ENTRY_W];
  end

  // offset uses the low six hash bits
  wire [5:0] mask = win[`RT_MASK_HI:`RT_MASK_LO];
  wire [2:0] shamt = win[`RT_SHIFT_HI:`RT_SHIFT_LO];
  wire [5:0] hash6 = hash_q[5:0];
  wire [5:0] masked = hash6 & mask;
  wire [5:0] offset = masked >> shamt;
  wire use_mp = ~win[`RT_MP_SEL_BIT];
  wire [10:0] base = win[`RT_NH_HI:`RT_NH_LO];
  wire [10:0] nh = use_mp ? base + {5'h0, offset} : base;
  wire any_hit = |hits;
  // next result values, zero pointer and generation on a miss
  wire hit_d = v_q & any_hit;
  wire miss_d = v_q & ~any_hit;
  wire [10:0] next_hop_d = hit_d ? nh : 11'h000;
  wire [2:0] generation_d = hit_d ? win[`RT_GEN_HI:`RT_GEN_LO] : 3'h0;

  always @(posedge CLK or negedge rstn_i) begin
    if (!rstn_i) begin
      RES_VALID <= 1'b0;
      RES_HIT <= 1'b0;
      RES_MISS <= 1'b0;
      RES_NEXT_HOP <= 11'h000;
      RES_GENERATION <= 3'h0;
    end else begin
      RES_VALID <= v_q;
      RES_HIT <= hit_d;
      RES_MISS <= miss_d;
      RES_NEXT_HOP <= next_hop_d;
      RES_GENERATION <= generation_d;
    end
  end
endmodule
`default_nettype wire

// [core/route_defs.vh]
// constants for the hashed layer-3 route lookup
`ifndef ROUTE_DEFS_VH
`define ROUTE_DEFS_VH
`define RT_TABLE_BASE 20'h5_4df0
`define RT_ROW_BITS 14
`define RT_BKT_BITS 2
`define RT_ENTRY_W 156
`define RT_ENTRY_RESET 156'h0
`define RT_AF_BIT 0
`define RT_MPLS_BIT 1
`define RT_VRF_LO 2
`define RT_VRF_HI 3
`define RT_ADDR_LO 4
`define RT_ADDR_HI 131
`define RT_NH_LO 132
`define RT_NH_HI 142
`define RT_MP_SEL_BIT 143
`define RT_MASK_LO 144
`define RT_MASK_HI 149
`define RT_SHIFT_LO 150
`define RT_SHIFT_HI 152
`define RT_GEN_LO 153
`define RT_GEN_HI 155
`define RT_PORT_W 4
`define RT_LABEL_W 20
`define RT_V4_W 32
`endif

// [core/route_bucket_cmp.v]
// one bucket compare of the route lookup
`timescale 1ns/1ps
`default_nettype none
`include "route_defs.vh"
module route_bucket_cmp (
  // stored entry
  input wire [`RT_ENTRY_W-1:0] entry,
  // packet key
  input wire key_family,
  input wire key_mpls,
  input wire [1:0] key_vrf,
  input wire [127:0] key_addr,
  // result
  output wire hit
);
  wire [127:0] stored = entry[`RT_ADDR_HI:`RT_ADDR_LO];
  wire fam_ok = entry[`RT_AF_BIT] == key_family;
  wire mpls_ok = entry[`RT_MPLS_BIT] == key_mpls;
  wire vrf_ok = entry[`RT_VRF_HI:`RT_VRF_LO] == key_vrf;
  wire v4_ok = stored[`RT_V4_W-1:0] == key_addr[`RT_V4_W-1:0];
  wire v6_ok = stored == key_addr;
  // port in low bits, label above
  wire mp_ok = stored[`RT_PORT_W+`RT_LABEL_W-1:0] ==
    key_addr[`RT_PORT_W+`RT_LABEL_W-1:0];
  reg addr_ok;
  always @* begin
    if (key_mpls)
      addr_ok = mp_ok;
    else if (key_family)
      addr_ok = v6_ok;
    else
      addr_ok = v4_ok;
  end
  // vrf not part of the mpls key
  assign hit = mpls_ok & (key_mpls | (fam_ok & vrf_ok)) & addr_ok;
endmodule
`default_nettype wire

// [verification/route_nh_model.sv]
// next-hop side: counts routed results
`timescale 1ns/1ps
`default_nettype none
module route_nh_model (
  input wire logic CLK,
  input wire logic RES_VALID,
  input wire logic RES_HIT,
  output var int hits
);
  initial hits = 0;
  always @(posedge CLK) if (RES_VALID && RES_HIT) hits <= hits + 1;
endmodule
`default_nettype wire

// [verification/route_lookup_properties.sv]
// port assertions for the route lookup
`timescale 1ns/1ps
`default_nettype none
module route_lookup_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CFG_RD,
  input wire logic CFG_RVALID,
  input wire logic [155:0] CFG_RDATA,
  input wire logic LK_VALID,
  input wire logic RES_VALID,
  input wire logic RES_HIT,
  input wire logic RES_MISS,
  input wire logic [10:0] RES_NEXT_HOP,
  input wire logic [2:0] RES_GENERATION
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  rd_answer_a: assert property (CFG_RD |=> CFG_RVALID) else $error("rd");
  rd_cause_a: assert property (CFG_RVALID |-> $past(CFG_RD)) else $error("rv");
  rdata_hold_a: assert property (!CFG_RD |=> $stable(CFG_RDATA)) else $error("rh");
  res_latency_a: assert property (LK_VALID |-> ##2 RES_VALID) else $error("lat");
  res_cause_a: assert property (RES_VALID |-> $past(LK_VALID, 2)) else $error("rc");
  hit_or_miss_a: assert property (RES_VALID |-> RES_HIT ^ RES_MISS) else $error("hm");
  miss_empty_a: assert property (RES_MISS |-> RES_NEXT_HOP == 0 && RES_GENERATION == 0)
    else $error("me");
  idle_quiet_a: assert property (!RES_VALID |-> !RES_HIT && !RES_MISS) else $error("iq");
endmodule
bind route_lookup route_lookup_props u_props (
  .CLK(CLK),
  .RSTN(RSTN),
  .CFG_RD(CFG_RD),
  .CFG_RVALID(CFG_RVALID),
  .CFG_RDATA(CFG_RDATA),
  .LK_VALID(LK_VALID),
  .RES_VALID(RES_VALID),
  .RES_HIT(RES_HIT),
  .RES_MISS(RES_MISS),
  .RES_NEXT_HOP(RES_NEXT_HOP),
  .RES_GENERATION(RES_GENERATION)
);
`default_nettype wire

// [verification/test_route_lookup.sv]
// self-checking bench for the route lookup
`timescale 1ns/1ps
`default_nettype none
module test_route_lookup;
  logic CLK = 0, RSTN = 0, CFG_WR = 0, CFG_RD = 0, LK_VALID = 0, LK_MPLS = 0, LK_FAMILY = 0;
  logic [15:0] CFG_INDEX = 0;
  logic [155:0] CFG_WDATA = 0, CFG_RDATA;
  logic [1:0] LK_VRF = 0;
  logic [127:0] LK_ADDR = 0;
  logic [3:0] LK_SRC_PORT = 0;
  logic [19:0] LK_LABEL = 0;
  logic [5:0] LK_MP_HASH = 0;
  logic [10:0] RES_NEXT_HOP;
  logic [2:0] RES_GENERATION;
  logic CFG_RVALID, RES_VALID, RES_HIT, RES_MISS;
  logic [159:0] e;
  logic [155:0] tbl[int];
  bit [31:0] rs = 75240;
  int n_fail = 0, n_checks = 0, hits, row, exp_hits = 0;
  always #2 CLK = ~CLK;
  route_lookup DUT (
    .CLK(CLK),
    .RSTN(RSTN),
    .CFG_WR(CFG_WR),
    .CFG_RD(CFG_RD),
    .CFG_INDEX(CFG_INDEX),
    .CFG_WDATA(CFG_WDATA),
    .CFG_RDATA(CFG_RDATA),
    .CFG_RVALID(CFG_RVALID),
    .LK_VALID(LK_VALID),
    .LK_MPLS(LK_MPLS),
    .LK_FAMILY(LK_FAMILY),
    .LK_VRF(LK_VRF),
    .LK_ADDR(LK_ADDR),
    .LK_SRC_PORT(LK_SRC_PORT),
    .LK_LABEL(LK_LABEL),
    .LK_MP_HASH(LK_MP_HASH),
    .RES_VALID(RES_VALID),
    .RES_HIT(RES_HIT),
    .RES_MISS(RES_MISS),
    .RES_NEXT_HOP(RES_NEXT_HOP),
    .RES_GENERATION(RES_GENERATION)
  );
  route_nh_model NH (
    .CLK(CLK),
    .RES_VALID(RES_VALID),
    .RES_HIT(RES_HIT),
    .hits(hits)
  );
  function automatic bit [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [127:0] key();
    return LK_MPLS ? {LK_LABEL, LK_SRC_PORT} : (LK_FAMILY ? LK_ADDR : LK_ADDR[31:0]) ^ LK_VRF;
  endfunction
  function automatic int fold(logic [127:0] k);
    int f = 0;
    for (int j = 0; j < 128; j++) f[j % 14] ^= k[j];
    return f;
  endfunction
  function automatic bit hit(logic [155:0] x);
    if (x[1] != LK_MPLS) return 0;
    if (LK_MPLS) return x[27:4] == {LK_LABEL, LK_SRC_PORT};
    if (x[0] != LK_FAMILY || x[3:2] != LK_VRF) return 0;
    return x[0] ? x[131:4] == LK_ADDR : x[35:4] == LK_ADDR[31:0];
  endfunction
  task automatic chk(string nm, logic [159:0] exp, logic [159:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(int i, logic [155:0] d);
    @(negedge CLK);
    CFG_WR = 1;
    CFG_INDEX = i[15:0];
    CFG_WDATA = d;
    @(negedge CLK) CFG_WR = 0;
  endtask
  task automatic rd(int i);
    @(negedge CLK);
    CFG_RD = 1;
    CFG_INDEX = i[15:0];
    @(negedge CLK) CFG_RD = 0;
    chk("rvalid", 1, CFG_RVALID);
    chk("rdata", tbl[i], CFG_RDATA);
  endtask
  task automatic look();
    bit [10:0] nh = 0;
    bit [2:0] g = 0;
    bit h = 0;
    for (int b = 3; b >= 0; b--) begin
      e = tbl[b * 16384 + fold(key())];
      if (hit(e[155:0])) begin
        h = 1;
        g = e[155:153];
        nh = e[142:132] + (e[143] ? 6'h0 : (LK_MP_HASH & e[149:144]) >> e[152:150]);
      end
    end
    @(negedge CLK) LK_VALID = 1;
    @(negedge CLK) LK_VALID = 0;
    @(negedge CLK);
    chk("valid", 1, RES_VALID);
    chk("miss", !h, RES_MISS);
    chk("hit", h, RES_HIT);
    exp_hits += h;
    chk("next hop", nh, RES_NEXT_HOP);
    chk("generation", g, RES_GENERATION);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d hits %0d", n_checks, n_fail, hits);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge CLK);
    RSTN = 1;
    repeat (3) @(negedge CLK);
    for (int t = 0; t < 40; t++) begin
      e = {rnd(), rnd(), rnd(), rnd(), rnd()};
      LK_ADDR = e[127:0];
      {LK_MPLS, LK_FAMILY, LK_VRF, LK_LABEL, LK_MP_HASH} = e[157:128];
      e[31:0] = rnd();
      LK_SRC_PORT = e[3:0];
      row = fold(key());
      for (int b = 0; b < 4; b++) begin
        e = {rnd(), rnd(), rnd(), rnd(), rnd()};
        if (e[0]) begin
          e[3:0] = {LK_VRF, LK_MPLS, LK_FAMILY} ^ (e[159:158] == 0 ? 4'h1 << e[157:156] : 4'h0);
          e[131:4] = LK_MPLS ? {e[131:28], LK_LABEL, LK_SRC_PORT} :
            LK_FAMILY ? LK_ADDR : {e[131:36], LK_ADDR[31:0]};
        end
        tbl[b * 16384 + row] = e[155:0];
        wr(b * 16384 + row, e[155:0]);
      end
      rd(e[1] * 16384 + row);
      look();
      $display("test %0d done", t);
    end
    // mid-run reset: outputs clear, table contents survive
    @(negedge CLK) RSTN = 0;
    @(negedge CLK);
    chk("reset rdata", 0, CFG_RDATA);
    chk("reset result", 0,
      {CFG_RVALID, RES_VALID, RES_HIT, RES_MISS, RES_NEXT_HOP, RES_GENERATION});
    @(negedge CLK) RSTN = 1;
    repeat (3) @(negedge CLK);
    look();
    $display("reset test done");
    @(negedge CLK);
    chk("hit count", exp_hits, hits);
    wrap_up();
  end
endmodule
`default_nettype wire
